// File: rtl/rssi_top.sv
`timescale 1ns/1ps
`default_nettype none
module rssi_top #(
  parameter int P_PULSE_CYC = rssi_pkg::PULSE_CYC,
  parameter int P_LEVEL_CYC = rssi_pkg::LEVEL_CYC,
  parameter int P_PWRUP_CYC = rssi_pkg::PWRUP_CYC,
  parameter int P_PWROFF_CYC = rssi_pkg::PWROFF_CYC,
  parameter int P_INIT_CYC = rssi_pkg::INIT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic run_level_in,
  input wire logic fault_detect_in,
  input wire logic reset_button_in,
  input wire logic power_ok_in,
  input wire logic [rssi_pkg::AW-1:0] addr,
  input wire logic [rssi_pkg::DW-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [rssi_pkg::DW-1:0] rd_data,
  output logic pump_run,
  output logic cryo_run,
  output logic running_ack_a,
  output logic running_ack_b,
  output logic fault_contact_a,
  output logic fault_contact_b,
  output logic irq
);

  generate
    if (P_PULSE_CYC < 1 || P_LEVEL_CYC < 1 || P_PWROFF_CYC < 1 ||
        P_PWRUP_CYC < 1 || P_INIT_CYC < P_PWRUP_CYC) begin : g_chk
      $error("rssi_top: bad timing parameters");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [rssi_pkg::NPIN-1:0] pin_raw;
  logic [rssi_pkg::NPIN-1:0] sync1_r;
  logic [rssi_pkg::NPIN-1:0] sync2_r;

  assign pin_raw = {power_ok_in, reset_button_in, fault_detect_in,
                    run_level_in, stop_in, start_in};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_r <= rssi_pkg::PIN_IDLE;
      sync2_r <= rssi_pkg::PIN_IDLE;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // command qualification

  logic [rssi_pkg::NCMD-1:0] qual_r;
  logic [rssi_pkg::NCMD-1:0] qual_prev_r;

  genvar gi;
  generate
    for (gi = 0; gi < rssi_pkg::NCMD; gi++) begin : g_qual
      localparam int LIM = (gi == rssi_pkg::IN_LEVEL) ? P_LEVEL_CYC : P_PULSE_CYC;
      logic [31:0] cnt_r;
      logic bit_r;
      wire differs = sync2_r[gi] != bit_r;
      wire done = cnt_r == 32'(LIM - 1);
      assign qual_r[gi] = bit_r;
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          cnt_r <= '0;
          bit_r <= rssi_pkg::PIN_IDLE[gi];
        end else if (!differs) begin
          cnt_r <= '0; // glitch shorter than LIM is dropped
        end else if (done) begin
          cnt_r <= '0;
          bit_r <= sync2_r[gi];
        end else begin
          cnt_r <= cnt_r + 32'h1;
        end
      end
    end
  endgenerate

  logic btn_prev_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      qual_prev_r <= '0;
      btn_prev_r <= 1'b0;
    end else begin
      qual_prev_r <= qual_r;
      btn_prev_r <= sync2_r[rssi_pkg::IN_BTN];
    end
  end

  wire q_start = qual_r[rssi_pkg::IN_START];
  wire q_stop = qual_r[rssi_pkg::IN_STOP];
  wire q_level = qual_r[rssi_pkg::IN_LEVEL];
  wire start_rise = q_start & ~qual_prev_r[rssi_pkg::IN_START];
  wire fault_s = sync2_r[rssi_pkg::IN_FAULT];
  wire btn_rise = sync2_r[rssi_pkg::IN_BTN] & ~btn_prev_r;
  wire pwr_ok = sync2_r[rssi_pkg::IN_PWR];

  //////////////////////////////////////////////////////////////////////////////
  // registers and state

  rssi_pkg::rssi_state_t state_r;
  rssi_pkg::rssi_state_t state_nxt;
  rssi_pkg::rssi_mode_t mode_r;
  rssi_pkg::rssi_mode_t mode_nxt;
  logic [31:0] tmr_r;
  logic [31:0] tmr_nxt;
  logic was_run_r;
  logic was_run_nxt;
  logic fault_latch_r;
  logic fault_latch_nxt;
  logic ctrl_ena_r;
  logic [rssi_pkg::EV_W-1:0] status_r;
  logic [rssi_pkg::EV_W-1:0] status_nxt;
  logic [rssi_pkg::EV_W-1:0] enable_r;
  logic [rssi_pkg::EV_W-1:0] ev;

  wire ena = ctrl_ena_r;
  wire mode_none = mode_r == rssi_pkg::MODE_NONE;
  wire is_pulse = mode_r == rssi_pkg::MODE_PULSE;
  wire is_level = mode_r == rssi_pkg::MODE_LEVEL;
  wire go_pulse = ena & start_rise & ~fault_latch_r & (mode_none | is_pulse);
  wire go_level = ena & q_level & ~fault_latch_r & (mode_none | is_level);
  wire stop_cond = fault_latch_r | (is_pulse & ~q_stop) | (is_level & ~q_level);
  wire init_done = tmr_r >= 32'(P_INIT_CYC - 1);
  wire off_done = tmr_r >= 32'(P_PWROFF_CYC - 1);

  //////////////////////////////////////////////////////////////////////////////
  // main sequencer

  always_comb begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    was_run_nxt = was_run_r;
    case (state_r)
      rssi_pkg::ST_INIT: begin
        if (init_done) begin
          state_nxt = rssi_pkg::ST_READY;
        end
      end
      rssi_pkg::ST_READY: begin
        if (go_pulse) begin
          state_nxt = rssi_pkg::ST_RUN;
          mode_nxt = rssi_pkg::MODE_PULSE;
        end else if (go_level) begin
          state_nxt = rssi_pkg::ST_RUN;
          mode_nxt = rssi_pkg::MODE_LEVEL;
        end
      end
      rssi_pkg::ST_RUN: begin
        if (stop_cond) begin
          state_nxt = rssi_pkg::ST_READY;
        end
      end
      rssi_pkg::ST_PWRLOSS: begin
        if (pwr_ok) begin
          state_nxt = (was_run_r && is_pulse) ? rssi_pkg::ST_RUN : rssi_pkg::ST_READY;
        end else if (off_done) begin
          state_nxt = rssi_pkg::ST_OFF;
        end
      end
      rssi_pkg::ST_OFF: begin
        if (pwr_ok) begin
          state_nxt = rssi_pkg::ST_INIT;
          mode_nxt = rssi_pkg::MODE_NONE;
        end
      end
      default: begin
        state_nxt = rssi_pkg::ST_INIT;
      end
    endcase
    if (!pwr_ok && state_r != rssi_pkg::ST_PWRLOSS && state_r != rssi_pkg::ST_OFF) begin
      state_nxt = rssi_pkg::ST_PWRLOSS;
      was_run_nxt = state_r == rssi_pkg::ST_RUN;
    end
  end

  assign tmr_nxt = (state_nxt != state_r) ? 32'h0 : tmr_r + 32'h1;
  assign fault_latch_nxt = fault_s | (fault_latch_r & ~(btn_rise & ~fault_s));

  wire run_nxt = state_nxt == rssi_pkg::ST_RUN;
  wire pwrup_win = state_nxt == rssi_pkg::ST_INIT && tmr_nxt < 32'(P_PWRUP_CYC);
  wire pwroff_win = state_nxt == rssi_pkg::ST_PWRLOSS;
  wire fault_close_nxt = fault_latch_nxt | pwrup_win | pwroff_win;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= rssi_pkg::ST_INIT;
      mode_r <= rssi_pkg::MODE_NONE;
      tmr_r <= '0;
      was_run_r <= 1'b0;
      fault_latch_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      tmr_r <= tmr_nxt;
      was_run_r <= was_run_nxt;
      fault_latch_r <= fault_latch_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // contact outputs

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pump_run <= 1'b0;
      cryo_run <= 1'b0;
      running_ack_a <= 1'b0;
      running_ack_b <= 1'b0;
      fault_contact_a <= 1'b0;
      fault_contact_b <= 1'b0;
    end else begin
      pump_run <= run_nxt;
      cryo_run <= run_nxt;
      running_ack_a <= run_nxt;
      running_ack_b <= run_nxt;
      fault_contact_a <= fault_close_nxt;
      fault_contact_b <= fault_close_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register port and interrupt

  assign ev[rssi_pkg::EV_START] = run_nxt & (state_r != rssi_pkg::ST_RUN);
  assign ev[rssi_pkg::EV_STOP] = ~run_nxt & (state_r == rssi_pkg::ST_RUN);
  assign ev[rssi_pkg::EV_FAULT] = fault_latch_nxt & ~fault_latch_r;
  assign ev[rssi_pkg::EV_MODE] = mode_none & (mode_nxt != rssi_pkg::MODE_NONE);
  assign ev[rssi_pkg::EV_PWR] = pwroff_win & (state_r != rssi_pkg::ST_PWRLOSS);

  wire wr_clr = wr_en && addr == rssi_pkg::A_CLEAR;
  wire wr_ena = wr_en && addr == rssi_pkg::A_ENABLE;
  wire wr_ctl = wr_en && addr == rssi_pkg::A_CTRL;
  wire [rssi_pkg::EV_W-1:0] clr_bits = wr_clr ? wr_data[rssi_pkg::EV_W-1:0] : '0;

  // set wins over clear
  assign status_nxt = (status_r & ~clr_bits) | ev;

  wire [rssi_pkg::DW-1:0] state_word = {26'h0, fault_latch_r,
                                         state_r, mode_r};
  wire [rssi_pkg::DW-1:0] rd_val =
    (addr == rssi_pkg::A_STATUS) ? {27'h0, status_r} :
    (addr == rssi_pkg::A_ENABLE) ? {27'h0, enable_r} :
    (addr == rssi_pkg::A_STATE) ? state_word :
    (addr == rssi_pkg::A_CTRL) ? {31'h0, ctrl_ena_r} :
    32'h0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_r <= '0;
      enable_r <= '0;
      ctrl_ena_r <= rssi_pkg::CTRL_ENA_RST;
      rd_data <= '0;
      irq <= 1'b0;
    end else begin
      status_r <= status_nxt;
      if (wr_ena) enable_r <= wr_data[rssi_pkg::EV_W-1:0];
      if (wr_ctl) ctrl_ena_r <= wr_data[rssi_pkg::CTRL_ENA];
      rd_data <= rd_en ? rd_val : 32'h0;
      irq <= |(status_nxt & enable_r);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence pulse_running_s;
    state_r == rssi_pkg::ST_RUN && is_pulse;
  endsequence

  sequence stop_drop_s;
    pulse_running_s ##0 !q_stop;
  endsequence

  mode_lock_a: assert property (
    (!mode_none && state_r != rssi_pkg::ST_OFF) |=> mode_r == $past(mode_r))
    else $error("mode changed while powered");

  run_pair_a: assert property (
    pump_run == cryo_run && running_ack_a == pump_run)
    else $error("pump and cryocooler outputs differ");

  pulse_latch_a: assert property (
    pulse_running_s ##0 (q_stop && !fault_latch_r && pwr_ok) |=> pump_run ##0 state_r == rssi_pkg::ST_RUN)
    else $error("pulse run state not latched");

  pulse_stop_a: assert property (
    stop_drop_s |=> !pump_run ##1 !running_ack_a)
    else $error("stop input did not stop pump");

  level_stop_a: assert property (
    (state_r == rssi_pkg::ST_RUN && is_level && !q_level) |=> !pump_run && !cryo_run)
    else $error("level drop did not stop pump");

  ack_follow_a: assert property (
    $rose(running_ack_a) |-> $past(state_nxt) == rssi_pkg::ST_RUN && pump_run)
    else $error("ack without run");

  fault_hold_a: assert property (
    (fault_latch_r && !(btn_rise && !fault_s)) |=> fault_latch_r && fault_contact_a)
    else $error("fault cleared without button");

  pwrup_close_a: assert property (
    (state_r == rssi_pkg::ST_INIT && tmr_r < 32'(P_PWRUP_CYC - 1)) |=> fault_contact_a)
    else $error("fault contact open during power-up window");

  init_quiet_a: assert property (
    state_r == rssi_pkg::ST_INIT |=> !pump_run && !running_ack_b)
    else $error("output driven during init");

  pwroff_close_a: assert property (
    (state_r == rssi_pkg::ST_PWRLOSS && !pwr_ok && !off_done) |=> fault_contact_b)
    else $error("fault contact open after switch-off");

endmodule : rssi_top
`default_nettype wire

// File: rtl/rssi_pkg.sv
// Behaviour
// - first qualified run command picks the mode
// - chosen mode holds until power removed
// - qualified start pulse latches running state
// - pump and cryocooler run outputs move together
// - stop low above 0.3 s stops, latches stopped
// - level mode runs while run level held
// - running ack follows pump running state
// - fault contact open when healthy, closed on fault
// - fault clears on button only when gone
// - switch-off closes fault contact about 2 s
// - power-up closes fault contact about 0.5 s
// - ack follows command within 0.3 s
// - run commands ignored and run outputs quiet during init
// - pulse mode restarts after short power dip
package rssi_pkg;
  localparam int CLK_KHZ = 50_000;
  localparam int PULSE_MS = 300;
  localparam int LEVEL_MS = 20;
  localparam int PWRUP_MS = 500;
  localparam int PWROFF_MS = 2000;
  localparam int INIT_MS = 5000;
  localparam int PULSE_CYC = CLK_KHZ * PULSE_MS;
  localparam int LEVEL_CYC = CLK_KHZ * LEVEL_MS;
  localparam int PWRUP_CYC = CLK_KHZ * PWRUP_MS;
  localparam int PWROFF_CYC = CLK_KHZ * PWROFF_MS;
  localparam int INIT_CYC = CLK_KHZ * INIT_MS;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_CLEAR = 8'h04;
  localparam logic [7:0] A_ENABLE = 8'h08;
  localparam logic [7:0] A_STATE = 8'h0c;
  localparam logic [7:0] A_CTRL = 8'h10;
  localparam int EV_W = 5;
  localparam int EV_START = 0;
  localparam int EV_STOP = 1;
  localparam int EV_FAULT = 2;
  localparam int EV_MODE = 3;
  localparam int EV_PWR = 4;
  localparam int CTRL_ENA = 0;
  localparam logic CTRL_ENA_RST = 1'b1;
  localparam int NPIN = 6;
  localparam int IN_START = 0;
  localparam int IN_STOP = 1;
  localparam int IN_LEVEL = 2;
  localparam int IN_FAULT = 3;
  localparam int IN_BTN = 4;
  localparam int IN_PWR = 5;
  localparam logic [NPIN-1:0] PIN_IDLE = 6'h22;
  localparam int NCMD = 3;
  typedef enum logic [1:0] {
    MODE_NONE = 2'b00,
    MODE_PULSE = 2'b01,
    MODE_LEVEL = 2'b10
  } rssi_mode_t;
  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_READY = 3'b001,
    ST_RUN = 3'b010,
    ST_PWRLOSS = 3'b011,
    ST_OFF = 3'b100
  } rssi_state_t;
endpackage : rssi_pkg

// File: tb/rssi_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module rssi_ctrl_model (
  input wire logic clk,
  output logic start_in,
  output logic stop_in,
  output logic run_level_in
);
  // pin image: [0] start, [1] stop, [2] run level
  logic [2:0] pin_r;
  assign {run_level_in, stop_in, start_in} = pin_r;
  initial begin
    pin_r = 3'h2;
  end
  // start held high n cycles; short n only as a deliberate glitch
  task automatic start_cmd(input int n);
    @(posedge clk);
    pin_r[0] <= 1'b1;
    repeat (n) @(posedge clk);
    pin_r[0] <= 1'b0;
  endtask : start_cmd
  // stop rests high, dropped low n cycles
  task automatic stop_cmd(input int n);
    @(posedge clk);
    pin_r[1] <= 1'b0;
    repeat (n) @(posedge clk);
    pin_r[1] <= 1'b1;
  endtask : stop_cmd
  // each level held n cycles before any further change
  task automatic level_cmd(input logic v, input int n);
    @(posedge clk);
    pin_r[2] <= v;
    repeat (n) @(posedge clk);
  endtask : level_cmd
endmodule : rssi_ctrl_model
`default_nettype wire

// File: tb/rssi_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module rssi_top_test;
  logic clk, rst, start_in, stop_in, run_level_in, fault_detect_in, reset_button_in;
  logic power_ok_in, wr_en, rd_en, pump_run, cryo_run, running_ack_a, running_ack_b;
  logic fault_contact_a, fault_contact_b, irq;
  logic [7:0] addr;
  logic [31:0] wr_data, rd_data, d;
  int num_errors = 0;
  int checks = 0;
  // env_r: [0] fault, [1] button, [2] power; strb_r: [1] write, [0] read
  logic [2:0] env_r;
  logic [1:0] strb_r;
  assign {power_ok_in, reset_button_in, fault_detect_in} = env_r;
  assign {wr_en, rd_en} = strb_r;
  ////////////////////////////////////////////////////////////////
  rssi_top #(.P_PULSE_CYC(8), .P_LEVEL_CYC(4), .P_PWRUP_CYC(20), .P_PWROFF_CYC(40),
    .P_INIT_CYC(50)) u_dut (.clk(clk), .rst(rst), .start_in(start_in), .stop_in(stop_in),
    .run_level_in(run_level_in), .fault_detect_in(fault_detect_in),
    .reset_button_in(reset_button_in), .power_ok_in(power_ok_in), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .pump_run(pump_run), .cryo_run(cryo_run), .running_ack_a(running_ack_a),
    .running_ack_b(running_ack_b), .fault_contact_a(fault_contact_a),
    .fault_contact_b(fault_contact_b), .irq(irq));
  rssi_ctrl_model u_ctrl (.clk(clk), .start_in(start_in), .stop_in(stop_in),
    .run_level_in(run_level_in));
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic end_of_test;
    if (num_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wr_data <= v;
    strb_r <= 2'h2;
    @(posedge clk);
    strb_r <= 2'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    strb_r <= 2'h1;
    @(posedge clk);
    strb_r <= 2'h0;
    #1;
    v = rd_data;
  endtask : rd
  // bounded wait for the pump, then all run outputs must agree
  task automatic wait_run(input logic v);
    for (int i = 0; i < 20 && pump_run !== v; i++) cyc(1);
    chk({28'h0, pump_run, cryo_run, running_ack_a, running_ack_b}, {28'h0, {4{v}}});
  endtask : wait_run
  task automatic press;
    @(posedge clk);
    env_r[1] <= 1'b1;
    repeat (3) @(posedge clk);
    env_r[1] <= 1'b0;
    cyc(6);
  endtask : press
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    env_r = 3'h4;
    strb_r = 2'h0;
    addr = 8'h00;
    wr_data = 32'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    cyc(3);
    chk(fault_contact_a, 1'b1);
    u_ctrl.start_cmd(12);
    cyc(10);
    chk({pump_run, fault_contact_a, fault_contact_b}, 3'h0);
    rd(rssi_pkg::A_STATE, d);
    chk(d[1:0], 2'h0);
    rd(rssi_pkg::A_CTRL, d);
    chk(d, 32'h1);
    rd(8'h14, d);
    chk(d, 32'h0);
    cyc(30);
    u_ctrl.start_cmd(4);
    cyc(12);
    chk(pump_run, 1'b0);
    u_ctrl.start_cmd(12);
    wait_run(1'b1);
    rd(rssi_pkg::A_STATE, d);
    chk(d[1:0], 2'h1);
    u_ctrl.level_cmd(1'b1, 10);
    u_ctrl.level_cmd(1'b0, 10);
    chk(pump_run, 1'b1);
    u_ctrl.stop_cmd(4);
    cyc(12);
    chk(pump_run, 1'b1);
    u_ctrl.stop_cmd(12);
    wait_run(1'b0);
    cyc(10);
    chk(pump_run, 1'b0);
    u_ctrl.start_cmd(12);
    wait_run(1'b1);
    env_r[2] <= 1'b0;
    cyc(8);
    chk({pump_run, fault_contact_a}, 2'h1);
    env_r[2] <= 1'b1;
    wait_run(1'b1);
    env_r[0] <= 1'b1;
    cyc(6);
    chk({pump_run, fault_contact_a, fault_contact_b}, 3'h3);
    press();
    chk(fault_contact_a, 1'b1);
    env_r[0] <= 1'b0;
    cyc(6);
    chk(fault_contact_a, 1'b1);
    press();
    chk({fault_contact_a, fault_contact_b}, 2'h0);
    wr(rssi_pkg::A_ENABLE, 32'h0);
    cyc(2);
    chk(irq, 1'b0);
    rd(rssi_pkg::A_STATUS, d);
    chk(d, 32'h1f);
    wr(rssi_pkg::A_ENABLE, 32'h4);
    cyc(2);
    chk(irq, 1'b1);
    rd(rssi_pkg::A_ENABLE, d);
    chk(d, 32'h4);
    wr(rssi_pkg::A_CLEAR, 32'h4);
    cyc(2);
    chk(irq, 1'b0);
    rd(rssi_pkg::A_STATUS, d);
    chk(d, 32'h1b);
    env_r[2] <= 1'b0;
    cyc(20);
    chk(fault_contact_a, 1'b1);
    cyc(40);
    chk(fault_contact_a, 1'b0);
    env_r[2] <= 1'b1;
    cyc(5);
    chk(fault_contact_a, 1'b1);
    cyc(60);
    u_ctrl.level_cmd(1'b1, 10);
    wait_run(1'b1);
    rd(rssi_pkg::A_STATE, d);
    chk(d[1:0], 2'h2);
    u_ctrl.start_cmd(12);
    cyc(4);
    rd(rssi_pkg::A_STATE, d);
    chk(d[1:0], 2'h2);
    u_ctrl.level_cmd(1'b0, 10);
    wait_run(1'b0);
    wr(rssi_pkg::A_CTRL, 32'h0);
    u_ctrl.level_cmd(1'b1, 10);
    cyc(4);
    chk(pump_run, 1'b0);
    rd(rssi_pkg::A_CTRL, d);
    chk(d, 32'h0);
    end_of_test();
  end
endmodule : rssi_top_test
`default_nettype wire
